/* File: hdl/cmstx_consts.vh */
// Constants for the multiplexed cell / MII / SMII transmit port
//
// Overview of operation
// [R1]: UTOPIA outputs change on transmit clock rises
// [R2]: Far side supplies MII clock, 25/2.5 MHz
// [R3]: SMII mode ignores shared transmit clock input
// [R4]: Multi-PHY: address with enable high, then low
// [R5]: Low enable marks cell data to PHY
// [R6]: Single-PHY: enable low means ready to send
// [R7]: Start flag high with first cell byte
// [R8]: UTOPIA cell bytes use all eight bits
// [R9]: MII nibbles on low four data bits
// [R10]: Bit four valid from preamble to last nibble
// [R11]: SMII serial on bit seven, MII unused
// [R12]: SMII shifts on common or source clock rise
// [R13]: Five-bit address polls, selects one PHY
// [R14]: No address hashing or filtering here
// [R15]: Polled PHY answers space one clock later
// [R16]: Outputs high impedance until interface enabled
`ifndef CMSTX_CONSTS_VH
`define CMSTX_CONSTS_VH

// Port modes
`define CMSTX_MODE_UTOPIA 2'h0
`define CMSTX_MODE_MII    2'h1
`define CMSTX_MODE_SMII   2'h2

// Transmit state codes
`define CMSTX_ST_IDLE 2'h0
`define CMSTX_ST_SEL  2'h1
`define CMSTX_ST_XFER 2'h2

// Levels and enables
`define CMSTX_EN_IDLE  1'h1
`define CMSTX_EN_SEND  1'h0
`define CMSTX_OE_OFF   1'h1
`define CMSTX_OE_ON    1'h0
`define CMSTX_ZERO8    8'h00
`define CMSTX_ZERO5    5'h00

// FIFO word layout: byte, start flag, end flag
`define CMSTX_FIFO_DEPTH 8
`define CMSTX_FIFO_WIDTH 10
`define CMSTX_F_SOF      8
`define CMSTX_F_EOF      9

// Pin positions inside the shared data bus
`define CMSTX_MII_VALID_BIT 4
`define CMSTX_SMII_BIT      7

// Serial bit counter bounds
`define CMSTX_BIT_FIRST 3'h0
`define CMSTX_BIT_LAST  3'h7
`define CMSTX_BIT_ONE   3'h1

// Synchronised pin indexes
`define CMSTX_SYN_CELL_CLK  0
`define CMSTX_SYN_SMII_COMMON_CLOCK  1
`define CMSTX_SYN_SMII_TX   2
`define CMSTX_SYN_SPACE     3
`define CMSTX_SYN_COUNT     4

`endif

/* File: hdl/cmstx_fifo.v */
// Small FIFO with a registered read word, sits in the transmit data path
`timescale 1ns/1ps
`default_nettype none

module cmstx_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst,
  // Fill side
  input  wire [WIDTH-1:0] i_wr_data,
  input  wire             i_wr_valid,
  output reg              o_wr_ready,
  // Drain side
  output reg  [WIDTH-1:0] o_rd_data,
  output reg              o_rd_valid,
  input  wire             i_rd_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
  reg [AW-1:0]    wp_r;            // Write pointer
  reg [AW-1:0]    rp_r;            // Read pointer
  reg [AW:0]      cnt_r;           // Words held in the array

  wire push;     // Word accepted from source
  wire fetch;    // Array word moves to output register

  // Full counts array only; output stage adds one spare word
  assign push       = i_wr_valid & o_wr_ready;
  assign fetch      = (cnt_r != {(AW+1){1'b0}}) & (~o_rd_valid | i_rd_ready);

  // Array write, no reset needed on data
  always @(posedge i_clk)
  begin
    if (push)
      mem[wp_r] <= i_wr_data;
  end

  // Pointers, count and registered read word
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp_r       <= {AW{1'b0}};
      rp_r       <= {AW{1'b0}};
      cnt_r      <= {(AW+1){1'b0}};
      o_rd_data  <= {WIDTH{1'b0}};
      o_rd_valid <= 1'b0;
      o_wr_ready <= 1'b1; // Empty array after reset
    end
    else
    begin
      if (push)
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      if (fetch)
      begin
        o_rd_data  <= mem[rp_r];
        o_rd_valid <= 1'b1;
        rp_r       <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      else if (i_rd_ready)
        o_rd_valid <= 1'b0; // Drained, nothing behind it
      // Ready is a flop so the user port sees no count decode glitch
      if (push & ~fetch)
      begin
        cnt_r      <= cnt_r + {{AW{1'b0}}, 1'b1};
        o_wr_ready <= (cnt_r != DEPTH[AW:0] - {{AW{1'b0}}, 1'b1}); // Last slot filling
      end
      else if (fetch & ~push)
      begin
        cnt_r      <= cnt_r - {{AW{1'b0}}, 1'b1};
        o_wr_ready <= 1'b1; // A slot was freed
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/cmstx_port.v */
// Transmit port: UTOPIA Level 2 master, MII nibble or SMII serial output
`timescale 1ns/1ps
`default_nettype none
`include "cmstx_consts.vh"

module cmstx_port #(
  parameter FIFO_DEPTH = `CMSTX_FIFO_DEPTH,
  parameter FIFO_AW    = 3
) (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // Configuration levels
  input  wire       i_if_enable,
  input  wire [1:0] i_port_mode,
  input  wire       i_multi_phy_mode,
  input  wire       i_smii_source_sync,
  input  wire [4:0] i_target_phy,
  // Byte stream from the user side
  input  wire [7:0] i_tx_byte,
  input  wire       i_tx_sof,
  input  wire       i_tx_eof,
  input  wire       i_tx_valid,
  output wire       o_tx_ready,
  // Link clocks and flow control pins
  input  wire       i_cell_tx_clock_in,
  input  wire       i_smii_common_clock,
  input  wire       i_smii_source_sync_tx_clock,
  input  wire       i_cell_tx_space_available_in,
  // Shared data bus pins
  output reg  [7:0] o_cell_tx_byte_bus,
  output reg        o_cell_tx_byte_bus_oe_n,
  // Cell control pins
  output reg        o_cell_tx_start_flag,
  output reg        o_cell_tx_start_flag_oe_n,
  output reg        o_cell_tx_enable_out_n,
  output reg        o_cell_tx_enable_out_oe_n,
  // PHY address pins
  output reg  [4:0] o_cell_tx_phy_select_bus,
  output reg        o_cell_tx_phy_select_bus_oe_n
);

  // Pin synchroniser stages, one bit per external input
  reg  [`CMSTX_SYN_COUNT-1:0] syn1_r;  // First stage, read by syn2 only
  reg  [`CMSTX_SYN_COUNT-1:0] syn2_r;  // Second stage
  reg  [`CMSTX_SYN_COUNT-1:0] syn3_r;  // Third stage
  reg  [`CMSTX_SYN_COUNT-1:0] lvl_r;   // Filtered level
  reg  [`CMSTX_SYN_COUNT-1:0] lvl_d_r; // Level one cycle back
  wire [`CMSTX_SYN_COUNT-1:0] pins;    // Raw pin vector
  wire [`CMSTX_SYN_COUNT-1:0] rise;    // Filtered rising edges

  // Transmit engine state
  reg  [1:0] state_r;    // Engine state
  reg        nib_hi_r;   // MII: high nibble is next
  reg  [2:0] bit_r;      // SMII: next bit of the byte
  reg        en_r;       // Registered interface enable
  reg        pop;        // Consume FIFO head this cycle
  wire       tick;       // Active link clock rise
  wire       multi;      // Multi-PHY UTOPIA operation

  // FIFO drain side
  wire [`CMSTX_FIFO_WIDTH-1:0] head;   // Head word
  wire                         head_v; // Head word valid
  wire [7:0]                   hbyte;  // Head data byte
  wire                         hsof;   // Head starts a cell or frame
  wire                         heof;   // Head ends a cell or frame

  assign pins = {i_cell_tx_space_available_in, i_smii_source_sync_tx_clock,
                 i_smii_common_clock, i_cell_tx_clock_in};

  // Three-stage synchroniser and edge finder per pin
  genvar g;
  generate
    for (g = 0; g < `CMSTX_SYN_COUNT; g = g + 1)
    begin : g_syn
      // Level moves only once stages two and three agree
      always @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          syn1_r[g]  <= 1'b0;
          syn2_r[g]  <= 1'b0;
          syn3_r[g]  <= 1'b0;
          lvl_r[g]   <= 1'b0;
          lvl_d_r[g] <= 1'b0;
        end
        else
        begin
          syn1_r[g]  <= pins[g];
          syn2_r[g]  <= syn1_r[g];
          syn3_r[g]  <= syn2_r[g];
          if (syn2_r[g] == syn3_r[g])
            lvl_r[g] <= syn3_r[g];
          lvl_d_r[g] <= lvl_r[g];
        end
      end
      assign rise[g] = lvl_r[g] & ~lvl_d_r[g];
    end
  endgenerate

  // Pick the clock that paces the current mode
  // SMII never looks at the shared transmit clock pin [R3]
  // SMII edge source follows the sync option [R12]
  assign tick = (i_port_mode == `CMSTX_MODE_SMII) ?
                (i_smii_source_sync ? rise[`CMSTX_SYN_SMII_TX] : rise[`CMSTX_SYN_SMII_COMMON_CLOCK]) :
                rise[`CMSTX_SYN_CELL_CLK]; // [R1]

  assign multi = i_multi_phy_mode & (i_port_mode == `CMSTX_MODE_UTOPIA);

  // Data path FIFO; back-pressure reaches the user through ready
  cmstx_fifo #(
    .WIDTH (`CMSTX_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_wr_data  ({i_tx_eof, i_tx_sof, i_tx_byte}),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .o_rd_data  (head),
    .o_rd_valid (head_v),
    .i_rd_ready (pop)
  );

  assign hbyte = head[7:0];
  assign hsof  = head[`CMSTX_F_SOF];
  assign heof  = head[`CMSTX_F_EOF];

  // Decide when the engine consumes the head word
  always @*
  begin
    pop = 1'b0;
    if (en_r && tick && head_v)
    begin
      case (i_port_mode)
        `CMSTX_MODE_UTOPIA:
        begin
          // Single-PHY sends straight from idle; multi-PHY after select
          if (state_r == `CMSTX_ST_XFER)
            pop = 1'b1;
          else if (state_r == `CMSTX_ST_IDLE)
            pop = ~multi;
          else
            pop = lvl_r[`CMSTX_SYN_SPACE];
        end
        `CMSTX_MODE_MII:
          pop = (state_r == `CMSTX_ST_XFER) & nib_hi_r;
        `CMSTX_MODE_SMII:
          pop = (state_r == `CMSTX_ST_XFER) & (bit_r == `CMSTX_BIT_LAST);
        default:
          pop = 1'b0;
      endcase
    end
  end

  // Output enables: every pin floats until the interface is enabled
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_r                          <= 1'b0;
      o_cell_tx_byte_bus_oe_n       <= `CMSTX_OE_OFF; // [R16]
      o_cell_tx_start_flag_oe_n     <= `CMSTX_OE_OFF;
      o_cell_tx_enable_out_oe_n     <= `CMSTX_OE_OFF;
      o_cell_tx_phy_select_bus_oe_n <= `CMSTX_OE_OFF;
    end
    else
    begin
      en_r                          <= i_if_enable;
      o_cell_tx_byte_bus_oe_n       <= en_r ? `CMSTX_OE_ON : `CMSTX_OE_OFF; // [R16]
      // Cell control pins only mean something in UTOPIA mode
      o_cell_tx_start_flag_oe_n     <= (en_r && i_port_mode == `CMSTX_MODE_UTOPIA) ?
                                       `CMSTX_OE_ON : `CMSTX_OE_OFF;
      o_cell_tx_enable_out_oe_n     <= (en_r && i_port_mode == `CMSTX_MODE_UTOPIA) ?
                                       `CMSTX_OE_ON : `CMSTX_OE_OFF;
      // Address bus driven only when several PHYs share the port
      o_cell_tx_phy_select_bus_oe_n <= (en_r && multi) ? `CMSTX_OE_ON : `CMSTX_OE_OFF; // [R13]
    end
  end

  // Transmit engine; while enabled, pins move only on a link clock rise
  // No address match or hash here: frames pass as queued [R14]
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r                  <= `CMSTX_ST_IDLE;
      nib_hi_r                 <= 1'b0;
      bit_r                    <= `CMSTX_BIT_FIRST;
      o_cell_tx_byte_bus       <= `CMSTX_ZERO8;
      o_cell_tx_start_flag     <= 1'b0;
      o_cell_tx_enable_out_n   <= `CMSTX_EN_IDLE;
      o_cell_tx_phy_select_bus <= `CMSTX_ZERO5;
    end
    else if (!en_r)
    begin
      // Disabled: park state, data and control pins, drop any partial transfer; address holds
      state_r                <= `CMSTX_ST_IDLE;
      nib_hi_r               <= 1'b0;
      bit_r                  <= `CMSTX_BIT_FIRST;
      o_cell_tx_byte_bus     <= `CMSTX_ZERO8;
      o_cell_tx_start_flag   <= 1'b0;
      o_cell_tx_enable_out_n <= `CMSTX_EN_IDLE;
    end
    else if (tick)
    begin
      case (i_port_mode)
        // Cell transfer, one byte per transmit clock
        `CMSTX_MODE_UTOPIA:
        begin
          case (state_r)
            `CMSTX_ST_IDLE:
            begin
              o_cell_tx_start_flag   <= 1'b0;
              o_cell_tx_enable_out_n <= `CMSTX_EN_IDLE;
              if (head_v && multi)
              begin
                // Address this clock, enable still high [R4]
                o_cell_tx_phy_select_bus <= i_target_phy; // [R13]
                state_r                  <= `CMSTX_ST_SEL;
              end
              else if (head_v)
              begin
                // Enable low: ready to send to the only PHY [R6]
                o_cell_tx_byte_bus     <= hbyte; // [R8]
                o_cell_tx_start_flag   <= hsof;  // [R7]
                o_cell_tx_enable_out_n <= `CMSTX_EN_SEND;
                state_r                <= heof ? `CMSTX_ST_IDLE : `CMSTX_ST_XFER;
              end
            end
            `CMSTX_ST_SEL:
            begin
              // Space answer arrives one clock after the address [R15]
              if (lvl_r[`CMSTX_SYN_SPACE] && head_v)
              begin
                o_cell_tx_byte_bus     <= hbyte;          // [R8]
                o_cell_tx_start_flag   <= hsof;           // [R7]
                o_cell_tx_enable_out_n <= `CMSTX_EN_SEND; // [R4]
                state_r                <= heof ? `CMSTX_ST_IDLE : `CMSTX_ST_XFER;
              end
              else
                state_r <= `CMSTX_ST_IDLE; // PHY full, poll again
            end
            `CMSTX_ST_XFER:
            begin
              if (head_v)
              begin
                // Enable low while cell bytes flow [R5]
                o_cell_tx_byte_bus     <= hbyte;          // [R8]
                o_cell_tx_start_flag   <= hsof;           // [R7]
                o_cell_tx_enable_out_n <= `CMSTX_EN_SEND; // [R5]
                if (heof)
                  state_r <= `CMSTX_ST_IDLE;
              end
              else
              begin
                // Underrun: pause the cell, keep the address
                o_cell_tx_start_flag   <= 1'b0;
                o_cell_tx_enable_out_n <= `CMSTX_EN_IDLE;
              end
            end
            default:
              state_r <= `CMSTX_ST_IDLE;
          endcase
        end
        // Frame transfer, low nibble first
        `CMSTX_MODE_MII:
        begin
          o_cell_tx_byte_bus[7:5] <= 3'h0; // Bit seven unused here [R11]
          case (state_r)
            `CMSTX_ST_IDLE:
            begin
              // Valid drops for one clock between frames
              o_cell_tx_byte_bus[`CMSTX_MII_VALID_BIT] <= 1'b0;
              if (head_v && !o_cell_tx_byte_bus[`CMSTX_MII_VALID_BIT])
              begin
                o_cell_tx_byte_bus[3:0]                  <= hbyte[3:0]; // [R9]
                o_cell_tx_byte_bus[`CMSTX_MII_VALID_BIT] <= 1'b1;       // [R10]
                nib_hi_r                                 <= 1'b1;
                state_r                                  <= `CMSTX_ST_XFER;
              end
            end
            `CMSTX_ST_XFER:
            begin
              if (nib_hi_r)
              begin
                o_cell_tx_byte_bus[3:0] <= hbyte[7:4]; // [R9]
                nib_hi_r                <= 1'b0;
                if (heof)
                  state_r <= `CMSTX_ST_IDLE; // Valid falls after this nibble [R10]
              end
              else if (head_v)
              begin
                o_cell_tx_byte_bus[3:0] <= hbyte[3:0];
                nib_hi_r                <= 1'b1;
              end
            end
            default:
              state_r <= `CMSTX_ST_IDLE;
          endcase
        end
        // Serial transfer, least significant bit first
        `CMSTX_MODE_SMII:
        begin
          o_cell_tx_byte_bus[6:0] <= 7'h00;
          case (state_r)
            `CMSTX_ST_IDLE:
            begin
              o_cell_tx_byte_bus[`CMSTX_SMII_BIT] <= 1'b0;
              if (head_v)
              begin
                o_cell_tx_byte_bus[`CMSTX_SMII_BIT] <= hbyte[0]; // [R11] [R12]
                bit_r                               <= `CMSTX_BIT_ONE;
                state_r                             <= `CMSTX_ST_XFER;
              end
            end
            `CMSTX_ST_XFER:
            begin
              if (bit_r != `CMSTX_BIT_FIRST || head_v)
              begin
                o_cell_tx_byte_bus[`CMSTX_SMII_BIT] <= hbyte[bit_r]; // [R11]
                bit_r                               <= bit_r + `CMSTX_BIT_ONE;
                if (bit_r == `CMSTX_BIT_LAST && heof)
                  state_r <= `CMSTX_ST_IDLE;
              end
              else
                o_cell_tx_byte_bus[`CMSTX_SMII_BIT] <= 1'b0; // Underrun idles low
            end
            default:
              state_r <= `CMSTX_ST_IDLE;
          endcase
        end
        default:
          state_r <= `CMSTX_ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: verification/cmstx_phy_model.sv */
// Far-side PHY model: link clocks and the polled space flag
`timescale 1ns/1ps
`default_nettype none

module cmstx_phy_model (
  // Controls from the bench
  input wire logic [2:0]  i_clk_en,
  input wire logic [31:0] i_full_mask,
  // Address pins from the port
  input wire logic [4:0]  i_addr,
  input wire logic        i_addr_oe_n,
  // Pins into the port
  output var logic        o_cell_clk,
  output var logic        o_smii_common_clock,
  output var logic        o_smii_src_clk,
  output var logic        o_space
);
  // Clocks stand at zero when stopped; odd offsets keep the two SMII clocks off the system phase
  // One process per pin keeps every pin single-driven
  initial
  begin
    o_cell_clk = 1'h0;
    forever #40 o_cell_clk = i_clk_en[0] ? ~o_cell_clk : 1'h0;
  end
  initial
  begin
    o_smii_common_clock = 1'h0;
    #3 forever #40 o_smii_common_clock = i_clk_en[1] ? ~o_smii_common_clock : 1'h0;
  end
  initial
  begin
    o_smii_src_clk = 1'h0;
    #7 forever #40 o_smii_src_clk = i_clk_en[2] ? ~o_smii_src_clk : 1'h0;
  end

  // Polled PHY answers one link clock after its address; pull-up when undriven
  initial
  begin
    o_space = 1'h1;
    forever @(posedge o_cell_clk) o_space <= i_addr_oe_n ? 1'h1 : !i_full_mask[i_addr];
  end
endmodule

`default_nettype wire

/* File: verification/cmstx_port_asserts.sv */
// Concurrent checks on the pins of the multiplexed transmit port
`timescale 1ns/1ps
`default_nettype none

module cmstx_port_asserts (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Configuration levels
  input wire logic       i_if_enable,
  input wire logic [1:0] i_port_mode,
  input wire logic       i_multi_phy_mode,
  // Link clock pin
  input wire logic       i_cell_tx_clock_in,
  // Driven pins
  input wire logic [7:0] o_cell_tx_byte_bus,
  input wire logic       o_cell_tx_byte_bus_oe_n,
  input wire logic       o_cell_tx_start_flag,
  input wire logic       o_cell_tx_start_flag_oe_n,
  input wire logic       o_cell_tx_enable_out_n,
  input wire logic       o_cell_tx_enable_out_oe_n,
  input wire logic [4:0] o_cell_tx_phy_select_bus,
  input wire logic       o_cell_tx_phy_select_bus_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [3:0] since_rise_r;  // Cycles since the link pin last rose
  logic       link_d_r;      // Link pin one cycle ago

  // Age of the last link rise, saturating so a stopped clock reads old
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      since_rise_r <= 4'hF;
      link_d_r     <= 1'h0;
    end
    else
    begin
      link_d_r     <= i_cell_tx_clock_in;
      if (i_cell_tx_clock_in && !link_d_r)
        since_rise_r <= 4'h0;
      else if (since_rise_r != 4'hF)
        since_rise_r <= since_rise_r + 4'h1;
    end
  end

  chk_pins_float_off: assert property (!i_if_enable [*2] |=> o_cell_tx_byte_bus_oe_n &&
    o_cell_tx_start_flag_oe_n && o_cell_tx_enable_out_oe_n && o_cell_tx_phy_select_bus_oe_n)
    else $error("pins still driven while disabled");
  chk_start_with_data: assert property (o_cell_tx_start_flag |-> !o_cell_tx_enable_out_n &&
    !o_cell_tx_start_flag_oe_n) else $error("start flag without data");
  chk_ctl_utopia_only: assert property (!o_cell_tx_enable_out_oe_n |-> i_port_mode == 2'h0)
    else $error("enable pin driven outside cell mode");
  chk_mii_upper_zero: assert property (i_port_mode == 2'h1 |-> o_cell_tx_byte_bus[7:5] == 3'h0)
    else $error("upper bits active in nibble mode");
  chk_smii_low_zero: assert property (i_port_mode == 2'h2 |-> o_cell_tx_byte_bus[6:0] == 7'h00)
    else $error("low bits active in serial mode");
  // Updates may only follow a link rise, never the system clock alone
  chk_link_paced: assert property (i_port_mode == 2'h0 && i_if_enable && $past(i_if_enable, 3) &&
    ($changed(o_cell_tx_enable_out_n) || $changed(o_cell_tx_byte_bus)) |-> since_rise_r <= 4'h7)
    else $error("cell output moved without a link edge");
  chk_select_first: assert property ($fell(o_cell_tx_enable_out_n) && i_multi_phy_mode |->
    $past(o_cell_tx_phy_select_bus, 6) == o_cell_tx_phy_select_bus && $past(o_cell_tx_enable_out_n, 6))
    else $error("enable fell without a prior select clock");
  chk_addr_hold: assert property (i_multi_phy_mode && $changed(o_cell_tx_phy_select_bus) |->
    o_cell_tx_enable_out_n) else $error("address moved during a transfer");

  cov_cell_start: cover property ($rose(o_cell_tx_start_flag));
  cov_multi_select: cover property (i_multi_phy_mode && $fell(o_cell_tx_enable_out_n));
  cov_nibble_frame: cover property (i_port_mode == 2'h1 && $rose(o_cell_tx_byte_bus[4]));
endmodule

bind cmstx_port cmstx_port_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_if_enable(i_if_enable),
  .i_port_mode(i_port_mode), .i_multi_phy_mode(i_multi_phy_mode), .i_cell_tx_clock_in(i_cell_tx_clock_in),
  .o_cell_tx_byte_bus(o_cell_tx_byte_bus), .o_cell_tx_byte_bus_oe_n(o_cell_tx_byte_bus_oe_n),
  .o_cell_tx_start_flag(o_cell_tx_start_flag), .o_cell_tx_start_flag_oe_n(o_cell_tx_start_flag_oe_n),
  .o_cell_tx_enable_out_n(o_cell_tx_enable_out_n), .o_cell_tx_enable_out_oe_n(o_cell_tx_enable_out_oe_n),
  .o_cell_tx_phy_select_bus(o_cell_tx_phy_select_bus),
  .o_cell_tx_phy_select_bus_oe_n(o_cell_tx_phy_select_bus_oe_n));

`default_nettype wire

/* File: verification/cmstx_port_tb_top.sv */
// Self-checking bench for the multiplexed transmit port
`timescale 1ns/1ps
`default_nettype none

module cmstx_port_tb_top;
  logic        clk, rst, if_en, multi, ss, valid, sof, eof;  // Driven inputs
  logic [1:0]  mode;
  logic [4:0]  target;
  logic [7:0]  tx_byte;
  logic [2:0]  clk_en;       // Which far-side clocks run
  logic [31:0] full_mask;    // PHYs that refuse cells
  logic        cell_clk, smii_common_clock, src_clk, space;
  logic        ready, start, start_oe_n, en_n, en_oe_n, bus_oe_n, addr_oe_n;
  logic [7:0]  bus;
  logic [4:0]  addr;
  logic [8:0]  capq[$];      // Captured start flag and bus per link clock
  logic        bitq[$];      // Captured serial bits
  int          bad_count, tests_run;

  cmstx_port #(.FIFO_DEPTH(8), .FIFO_AW(3)) DUT (.i_clk(clk), .i_rst(rst), .i_if_enable(if_en),
    .i_port_mode(mode), .i_multi_phy_mode(multi), .i_smii_source_sync(ss), .i_target_phy(target),
    .i_tx_byte(tx_byte), .i_tx_sof(sof), .i_tx_eof(eof), .i_tx_valid(valid), .o_tx_ready(ready),
    .i_cell_tx_clock_in(cell_clk), .i_smii_common_clock(smii_common_clock), .i_smii_source_sync_tx_clock(src_clk),
    .i_cell_tx_space_available_in(space), .o_cell_tx_byte_bus(bus), .o_cell_tx_byte_bus_oe_n(bus_oe_n),
    .o_cell_tx_start_flag(start), .o_cell_tx_start_flag_oe_n(start_oe_n), .o_cell_tx_enable_out_n(en_n),
    .o_cell_tx_enable_out_oe_n(en_oe_n), .o_cell_tx_phy_select_bus(addr),
    .o_cell_tx_phy_select_bus_oe_n(addr_oe_n));
  cmstx_phy_model u_phy (.i_clk_en(clk_en), .i_full_mask(full_mask), .i_addr(addr), .i_addr_oe_n(addr_oe_n),
    .o_cell_clk(cell_clk), .o_smii_common_clock(smii_common_clock), .o_smii_src_clk(src_clk), .o_space(space));

  always #5 clk = ~clk;

  // Sample as the PHY does, on the link rise
  always @(posedge cell_clk)
    if (!rst && ((mode == 2'h0 && en_n === 1'h0) || (mode == 2'h1 && bus[4] === 1'h1)))
      capq.push_back({start, bus});
  always @(posedge (ss ? src_clk : smii_common_clock))
    if (!rst && mode == 2'h2)
      bitq.push_back(bus[7]);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset for five cycles with the mode set, then enable
  task automatic do_reset(input logic [1:0] m, input logic mp, input logic s);
    rst <= 1'h1;
    if_en <= 1'h0;
    mode <= m;
    multi <= mp;
    ss <= s;
    repeat (5) @(posedge clk);
    check("oe in reset", {bus_oe_n, start_oe_n, en_oe_n, addr_oe_n, ready}, 16'h1F);
    rst <= 1'h0;
    if_en <= 1'h1;
    repeat (3) @(posedge clk);
    capq.delete();
    bitq.delete();
  endtask

  // Hold one word until ready is seen at a falling edge, then through the next rising edge
  task automatic send(input logic [9:0] w);
    int n;
    n = 0;
    tx_byte <= w[7:0];
    sof <= w[8];
    eof <= w[9];
    valid <= 1'h1;
    @(negedge clk);
    while (ready !== 1'h1 && n < 400)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 400)
      check("ready wait", 16'h0, 16'h1);
    @(posedge clk);
  endtask

  task automatic wait_cap(input int k);
    int n;
    for (n = 0; n < 3000 && capq.size() < k; n++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    check("link count", 16'(capq.size()), 16'(k));
  endtask

  task automatic t_enable_pins;
    do_reset(2'h0, 1'h0, 1'h0);
    check("oe enabled", {bus_oe_n, start_oe_n, en_oe_n, addr_oe_n}, 16'h1);
  endtask

  task automatic t_single_cell;
    do_reset(2'h0, 1'h0, 1'h0);
    send(10'h1A5);
    send(10'h05A);
    send(10'h2FF);
    valid <= 1'h0;
    wait_cap(3);
    check("cell b0", 16'(capq[0]), 16'h1A5);
    check("cell b1", 16'(capq[1]), 16'h05A);
    check("cell b2", 16'(capq[2]), 16'h0FF);
  endtask

  // Fill against a full PHY, then drain once it has space
  task automatic t_multi_fill;
    int i;
    do_reset(2'h0, 1'h1, 1'h0);
    target <= 5'h13;
    full_mask <= 32'h0008_0000;
    for (i = 0; i < 9; i++)
      send({i == 8, i == 0, 8'h10 + 8'(i)});
    valid <= 1'h0;
    @(negedge clk);
    check("fifo full", {15'h0, ready}, 16'h0);
    repeat (80) @(posedge clk);
    check("stalled", 16'(capq.size()), 16'h0);
    full_mask <= 32'h0;
    wait_cap(9);
    for (i = 0; i < 9; i++)
      check("drained", 16'(capq[i]), {7'h0, i == 0, 8'h10 + 8'(i)});
    check("phy addr", {10'h0, addr_oe_n, addr}, 16'h13);
  endtask

  task automatic t_mii_frame;
    int i;
    do_reset(2'h1, 1'h0, 1'h0);
    send(10'h121);
    send(10'h243);
    valid <= 1'h0;
    wait_cap(4);
    for (i = 0; i < 4; i++)
      check("nibble", 16'(capq[i][4:0]), 16'h11 + 16'(i));
  endtask

  // Serial bits LSB first on the chosen clock; cell clock stopped, then running,
  // so a port that paced SMII from the shared clock fails the first pass
  task automatic t_smii;
    int i, n, s;
    logic [15:0] v;
    for (i = 0; i < 2; i++)
    begin
      do_reset(2'h2, 1'h0, 1'(i));
      clk_en <= (i == 1) ? 3'h5 : 3'h2;
      send(10'h1B5);
      send(10'h23C);
      valid <= 1'h0;
      for (n = 0; n < 4000 && bitq.size() < 30; n++)
        @(posedge clk);
      s = -1;
      foreach (bitq[k])
        if (s < 0 && bitq[k] === 1'h1)
          s = k;
      for (n = 0; n < 16; n++)
        v[n] = (s >= 0 && s + n < bitq.size()) ? bitq[s + n] : 1'hx;
      check("serial", v, 16'h3CB5);
      clk_en <= 3'h1;
    end
  endtask

  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    {if_en, multi, ss, valid, sof, eof} = 6'h0;
    mode = 2'h0;
    target = 5'h00;
    tx_byte = 8'h00;
    clk_en = 3'h1;
    full_mask = 32'h0;
    t_enable_pins();
    t_single_cell();
    t_multi_fill();
    t_mii_frame();
    t_smii();
    report_and_stop();
  end

  initial
  begin
    #300000;
    bad_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
